// >>> rtl/drec_pkg.sv
/*
  Shared constants and carrier types of the disturbance recorder.
  Assumes one 200 MHz clock and a base sample tick from the measuring front end.
*/
`default_nettype none

package drec_pkg;

  // Register offsets, byte addresses on the plain register port.
  localparam logic [7:0] OFS_DIG_SEL_LOW    = 8'h00;
  localparam logic [7:0] OFS_DIG_SEL_HIGH   = 8'h04;
  localparam logic [7:0] OFS_SAMPLE_RATE    = 8'h08;
  localparam logic [7:0] OFS_POST_LEN       = 8'h0C;
  localparam logic [7:0] OFS_TRIG_RISE      = 8'h10;
  localparam logic [7:0] OFS_TRIG_FALL      = 8'h14;
  localparam logic [7:0] OFS_STATE_UPLOAD   = 8'h18;
  localparam logic [7:0] OFS_MANUAL_TRIG    = 8'h1C;
  localparam logic [7:0] OFS_CLEAR          = 8'h20;
  localparam logic [7:0] OFS_EVENT_MASK     = 8'h24;
  localparam logic [7:0] OFS_PREREQ_A       = 8'h28;
  localparam logic [7:0] OFS_PREREQ_B       = 8'h2C;
  localparam logic [7:0] OFS_UPLOAD_DATA    = 8'h30;
  localparam logic [7:0] OFS_CONFIG         = 8'h34;
  localparam logic [7:0] OFS_FILL           = 8'h38;

  // Channel geometry.
  localparam int N_ANALOG   = 4;
  localparam int ANA_W      = 12;
  localparam int N_INTERNAL = 10;
  localparam int N_SIG      = 11;
  localparam int N_DIG      = 8;
  localparam int EXT_BIT    = 10;
  localparam int SAMPLE_W   = 56;

  // Buffer geometry: every rate setting yields 512 stored samples.
  localparam int DEPTH      = 512;
  localparam int AW         = 9;
  localparam int CW         = 10;
  localparam logic [CW-1:0] DEPTH_CNT = 10'h200;

  // Sample rate codes and base-tick divisors (base tick is 16 x nominal).
  localparam logic [1:0] RATE_16X = 2'h0;
  localparam logic [1:0] RATE_8X  = 2'h1;
  localparam logic [1:0] RATE_1X  = 2'h2;
  localparam logic [4:0] DIV_16X  = 5'h01;
  localparam logic [4:0] DIV_8X   = 5'h02;
  localparam logic [4:0] DIV_1X   = 5'h10;

  // Command values and reset values.
  localparam logic [31:0] CMD_ONE        = 32'h0000_0001;
  localparam logic [31:0] CMD_UPLOAD_RST = 32'h0000_0002;
  localparam logic [31:0] STAT_IDLE      = 32'h0000_0000;
  localparam logic [31:0] STAT_READY     = 32'h0000_0001;
  localparam logic        MASK_RESET     = 1'b1;
  localparam int          CFG_NV_BIT     = 0;
  localparam int          CFG_60HZ_BIT   = 1;

  // Upload word phases.
  localparam logic [1:0] UPL_STAMP = 2'h0;
  localparam logic [1:0] UPL_W0    = 2'h1;
  localparam logic [1:0] UPL_W1    = 2'h2;

  typedef enum logic [1:0] {
    DREC_UNTRIGGERED,
    DREC_POST,
    DREC_READY
  } drec_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } drec_req_t;

  typedef struct packed {
    logic [N_ANALOG-1:0][ANA_W-1:0] inst;
    logic [N_ANALOG-1:0][ANA_W-1:0] rms;
  } drec_analog_t;

endpackage : drec_pkg

`default_nettype wire

// >>> rtl/drec_recorder.sv
/*
  Disturbance recorder core: circular sample buffer, triggering, post-trigger
  capture, status and upload over a plain register port.
  Assumes all inputs synchronous to clk and a base tick at 16 x nominal frequency.
*/
`default_nettype none

module drec_recorder (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire drec_pkg::drec_req_t  bus_req,
  output var  logic [31:0]          rd_data,
  input  wire logic                 base_tick,
  input  wire drec_pkg::drec_analog_t analog_in,
  input  wire logic [drec_pkg::N_INTERNAL-1:0] prot_signals,
  input  wire logic                 binary_input,
  input  wire logic [31:0]          time_stamp,
  input  wire logic                 display_idle,
  input  wire logic                 power_restart,
  output var  logic                 trigger_event,
  output var  logic                 ready_mark
);

  // Picks the first eight selected signals, internal ones first.
  function automatic logic [drec_pkg::N_DIG-1:0] pack_digital(
    input logic [drec_pkg::N_SIG-1:0] sig,
    input logic [drec_pkg::N_SIG-1:0] sel
  );
    logic [drec_pkg::N_DIG-1:0] o;
    logic [3:0]                 n;
    o = '0;
    n = 4'h0;
    for (int i = 0; i < drec_pkg::N_SIG; i++) begin
      if (sel[i] && (n < 4'(drec_pkg::N_DIG))) begin
        o[n[2:0]] = sig[i];
        n = n + 4'h1;
      end
    end
    return o;
  endfunction : pack_digital

  drec_pkg::drec_state_t           state_reg;
  logic [drec_pkg::N_SIG-1:0]      dig_sel_reg;
  logic [1:0]                      rate_reg;
  logic [drec_pkg::CW-1:0]         post_len_reg;
  logic [drec_pkg::N_SIG-1:0]      rise_en_reg;
  logic [drec_pkg::N_SIG-1:0]      fall_en_reg;
  logic                            mask_reg;
  logic [31:0]                     prereq_a_reg;
  logic [31:0]                     prereq_b_reg;
  logic                            nv_reg;
  logic                            hz60_reg;
  logic [4:0]                      div_cnt_reg;
  logic [drec_pkg::N_SIG-1:0]      sig_prev_reg;
  logic [drec_pkg::AW-1:0]         wr_ptr_reg;
  logic [drec_pkg::CW-1:0]         fill_reg;
  logic [drec_pkg::CW-1:0]         post_cnt_reg;
  logic [31:0]                     stamp_reg;
  logic [1:0]                      upl_phase_reg;
  logic [drec_pkg::CW-1:0]         upl_idx_reg;
  logic [drec_pkg::SAMPLE_W-1:0]   mem [drec_pkg::DEPTH];

  logic [drec_pkg::N_SIG-1:0]      sig_now;
  logic [4:0]                      div_limit;
  logic                            tick;
  logic                            wr_hit;
  logic                            rd_hit;
  logic                            clear_cmd;
  logic                            manual_cmd;
  logic                            edge_hit;
  logic                            trig_now;
  logic                            post_done;
  logic                            untrig;
  logic                            upl_ok;
  logic [drec_pkg::SAMPLE_W-1:0]   sample_word;
  logic [drec_pkg::N_ANALOG-1:0][drec_pkg::ANA_W-1:0] ana_sel;
  logic [drec_pkg::AW-1:0]         upl_addr;
  logic [drec_pkg::SAMPLE_W-1:0]   upl_entry;

  // Decodes of the register port and the trigger sources.
  assign untrig     = (state_reg == drec_pkg::DREC_UNTRIGGERED);
  assign wr_hit     = bus_req.wr;
  assign rd_hit     = bus_req.rd;
  assign clear_cmd  = wr_hit && (bus_req.addr == drec_pkg::OFS_CLEAR)
                      && (bus_req.wdata == drec_pkg::CMD_ONE);
  assign manual_cmd = wr_hit && (bus_req.addr == drec_pkg::OFS_MANUAL_TRIG)
                      && (bus_req.wdata == drec_pkg::CMD_ONE);
  assign sig_now    = {binary_input, prot_signals};
  assign edge_hit   = |((sig_now & ~sig_prev_reg & rise_en_reg)
                      | (~sig_now & sig_prev_reg & fall_en_reg));
  assign trig_now   = untrig && !clear_cmd && (edge_hit || manual_cmd);
  assign upl_ok     = (prereq_a_reg != '0) && (prereq_b_reg != '0);

  // Divides the base tick down to the selected sample rate.
  always_comb begin
    case (rate_reg)
      drec_pkg::RATE_16X: begin
        div_limit = drec_pkg::DIV_16X;
      end
      drec_pkg::RATE_8X: begin
        div_limit = drec_pkg::DIV_8X;
      end
      drec_pkg::RATE_1X: begin
        div_limit = drec_pkg::DIV_1X;
      end
      default: begin
        div_limit = drec_pkg::DIV_16X;
      end
    endcase
  end

  assign tick = base_tick && (div_cnt_reg == div_limit - 5'h01);

  // The 1x rate equals nominal frequency, so RMS curves replace raw samples.
  assign ana_sel     = (rate_reg == drec_pkg::RATE_1X) ? analog_in.rms
                                                       : analog_in.inst;
  assign sample_word = {pack_digital(sig_now, dig_sel_reg), ana_sel};
  assign post_done   = tick && (state_reg == drec_pkg::DREC_POST)
                       && (post_cnt_reg + 10'h001 >= post_len_reg);

  // Upload walks from the oldest entry; before wrap the oldest is entry zero.
  assign upl_addr  = (fill_reg == drec_pkg::DEPTH_CNT)
                     ? drec_pkg::AW'(wr_ptr_reg + upl_idx_reg[drec_pkg::AW-1:0])
                     : upl_idx_reg[drec_pkg::AW-1:0];
  assign upl_entry = mem[upl_addr];

  // Base tick divider; restarted by reset and by the clear command.
  always_ff @(posedge clk) begin
    if (rst || clear_cmd) begin
      div_cnt_reg <= 5'h00;
    end else if (base_tick) begin
      div_cnt_reg <= tick ? 5'h00 : div_cnt_reg + 5'h01;
    end
  end

  // Previous signal levels for edge detection.
  always_ff @(posedge clk) begin
    if (rst) begin
      sig_prev_reg <= '0;
    end else begin
      sig_prev_reg <= sig_now;
    end
  end

  // Settings; rate and channel selection are frozen outside the untriggered state.
  always_ff @(posedge clk) begin
    if (rst) begin
      dig_sel_reg  <= '0;
      rate_reg     <= drec_pkg::RATE_16X;
      post_len_reg <= drec_pkg::DEPTH_CNT;
      rise_en_reg  <= '0;
      fall_en_reg  <= '0;
      mask_reg     <= drec_pkg::MASK_RESET;
      prereq_a_reg <= '0;
      prereq_b_reg <= '0;
      nv_reg       <= 1'b0;
      hz60_reg     <= 1'b0;
    end else if (wr_hit) begin
      case (bus_req.addr)
        drec_pkg::OFS_DIG_SEL_LOW: begin
          if (untrig) begin
            dig_sel_reg[drec_pkg::N_INTERNAL-1:0] <=
              bus_req.wdata[drec_pkg::N_INTERNAL-1:0];
          end
        end
        drec_pkg::OFS_DIG_SEL_HIGH: begin
          if (untrig) begin
            dig_sel_reg[drec_pkg::EXT_BIT] <= bus_req.wdata[0];
          end
        end
        drec_pkg::OFS_SAMPLE_RATE: begin
          if (untrig && (bus_req.wdata[1:0] <= drec_pkg::RATE_1X)) begin
            rate_reg <= bus_req.wdata[1:0];
          end
        end
        drec_pkg::OFS_POST_LEN: begin
          // Lengths beyond the buffer are clipped so the capture still ends.
          if (bus_req.wdata > 32'(drec_pkg::DEPTH)) begin
            post_len_reg <= drec_pkg::DEPTH_CNT;
          end else begin
            post_len_reg <= bus_req.wdata[drec_pkg::CW-1:0];
          end
        end
        // Trigger enables may change at any time; they only matter while armed.
        drec_pkg::OFS_TRIG_RISE: begin
          rise_en_reg <= bus_req.wdata[drec_pkg::N_SIG-1:0];
        end
        drec_pkg::OFS_TRIG_FALL: begin
          fall_en_reg <= bus_req.wdata[drec_pkg::N_SIG-1:0];
        end
        drec_pkg::OFS_EVENT_MASK: begin
          mask_reg <= bus_req.wdata[0];
        end
        drec_pkg::OFS_PREREQ_A: begin
          prereq_a_reg <= bus_req.wdata;
        end
        drec_pkg::OFS_PREREQ_B: begin
          prereq_b_reg <= bus_req.wdata;
        end
        drec_pkg::OFS_CONFIG: begin
          nv_reg   <= bus_req.wdata[drec_pkg::CFG_NV_BIT];
          hz60_reg <= bus_req.wdata[drec_pkg::CFG_60HZ_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Recorder state: arm, post-trigger capture, frozen and ready.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= drec_pkg::DREC_UNTRIGGERED;
    end else if (clear_cmd) begin
      state_reg <= drec_pkg::DREC_UNTRIGGERED;
    end else if (power_restart && !(nv_reg && state_reg == drec_pkg::DREC_READY)) begin
      state_reg <= drec_pkg::DREC_UNTRIGGERED;
    end else begin
      case (state_reg)
        drec_pkg::DREC_UNTRIGGERED: begin
          if (trig_now) begin
            state_reg <= drec_pkg::DREC_POST;
          end
        end
        drec_pkg::DREC_POST: begin
          if (post_done) begin
            state_reg <= drec_pkg::DREC_READY;
          end
        end
        // Held until clear, master reset or a volatile power restart.
        drec_pkg::DREC_READY: begin
          state_reg <= drec_pkg::DREC_READY;
        end
        default: begin
          state_reg <= drec_pkg::DREC_UNTRIGGERED;
        end
      endcase
    end
  end

  // Post-trigger sample counter and the trigger time stamp.
  always_ff @(posedge clk) begin
    if (rst) begin
      post_cnt_reg <= '0;
      stamp_reg    <= '0;
    end else if (trig_now) begin
      post_cnt_reg <= '0;
      stamp_reg    <= time_stamp;
    end else if (tick && state_reg == drec_pkg::DREC_POST) begin
      post_cnt_reg <= post_cnt_reg + 10'h001;
    end
  end

  // Circular storage; erase costs a wide reset fan-out but keeps stale data unreadable.
  always_ff @(posedge clk) begin
    if (rst || clear_cmd
        || (power_restart && !(nv_reg && state_reg == drec_pkg::DREC_READY))) begin
      wr_ptr_reg <= '0;
      fill_reg   <= '0;
      for (int i = 0; i < drec_pkg::DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (tick && state_reg != drec_pkg::DREC_READY) begin
      mem[wr_ptr_reg] <= sample_word;
      wr_ptr_reg      <= wr_ptr_reg + 9'h001;
      if (fill_reg != drec_pkg::DEPTH_CNT) begin
        fill_reg <= fill_reg + 10'h001;
      end
    end
  end

  // Upload walker: time stamp first, then two words per sample.
  always_ff @(posedge clk) begin
    if (rst || clear_cmd || state_reg != drec_pkg::DREC_READY) begin
      upl_phase_reg <= drec_pkg::UPL_STAMP;
      upl_idx_reg   <= '0;
    end else if (wr_hit && bus_req.addr == drec_pkg::OFS_STATE_UPLOAD
                 && bus_req.wdata == drec_pkg::CMD_UPLOAD_RST) begin
      upl_phase_reg <= drec_pkg::UPL_STAMP;
      upl_idx_reg   <= '0;
    end else if (rd_hit && bus_req.addr == drec_pkg::OFS_UPLOAD_DATA && upl_ok) begin
      case (upl_phase_reg)
        drec_pkg::UPL_STAMP: begin
          upl_phase_reg <= drec_pkg::UPL_W0;
        end
        drec_pkg::UPL_W0: begin
          upl_phase_reg <= drec_pkg::UPL_W1;
        end
        // The walker parks on the last word so extra reads cannot run past the data.
        drec_pkg::UPL_W1: begin
          if (upl_idx_reg + 10'h001 < fill_reg) begin
            upl_idx_reg   <= upl_idx_reg + 10'h001;
            upl_phase_reg <= drec_pkg::UPL_W0;
          end
        end
        default: begin
          upl_phase_reg <= drec_pkg::UPL_STAMP;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (rst || !rd_hit) begin
      rd_data <= '0;
    end else begin
      case (bus_req.addr)
        drec_pkg::OFS_DIG_SEL_LOW:  rd_data <= 32'(dig_sel_reg[drec_pkg::N_INTERNAL-1:0]);
        drec_pkg::OFS_DIG_SEL_HIGH: rd_data <= 32'(dig_sel_reg[drec_pkg::EXT_BIT]);
        drec_pkg::OFS_SAMPLE_RATE:  rd_data <= 32'(rate_reg);
        drec_pkg::OFS_POST_LEN:     rd_data <= 32'(post_len_reg);
        drec_pkg::OFS_TRIG_RISE:    rd_data <= 32'(rise_en_reg);
        drec_pkg::OFS_TRIG_FALL:    rd_data <= 32'(fall_en_reg);
        drec_pkg::OFS_STATE_UPLOAD: begin
          rd_data <= (state_reg == drec_pkg::DREC_READY) ? drec_pkg::STAT_READY
                                                         : drec_pkg::STAT_IDLE;
        end
        drec_pkg::OFS_EVENT_MASK:   rd_data <= 32'(mask_reg);
        drec_pkg::OFS_PREREQ_A:     rd_data <= prereq_a_reg;
        drec_pkg::OFS_PREREQ_B:     rd_data <= prereq_b_reg;
        drec_pkg::OFS_CONFIG:       rd_data <= 32'({hz60_reg, nv_reg});
        drec_pkg::OFS_FILL:         rd_data <= 32'(fill_reg);
        drec_pkg::OFS_UPLOAD_DATA: begin
          // Uploading without prerequisites or a finished recording yields zeros.
          if (!upl_ok || state_reg != drec_pkg::DREC_READY) begin
            rd_data <= '0;
          end else if (upl_phase_reg == drec_pkg::UPL_STAMP) begin
            rd_data <= stamp_reg;
          end else if (upl_phase_reg == drec_pkg::UPL_W0) begin
            rd_data <= 32'(upl_entry[2*drec_pkg::ANA_W-1:0]);
          end else begin
            rd_data <= upl_entry[drec_pkg::SAMPLE_W-1:2*drec_pkg::ANA_W];
          end
        end
        default: rd_data <= '0;
      endcase
    end
  end

  // Event pulse at the trigger instant and the display ready mark.
  always_ff @(posedge clk) begin
    if (rst) begin
      trigger_event <= 1'b0;
      ready_mark    <= 1'b0;
    end else begin
      trigger_event <= trig_now && mask_reg;
      ready_mark    <= (state_reg == drec_pkg::DREC_READY) && display_idle;
    end
  end

endmodule : drec_recorder

`default_nettype wire

// >>> verification/disturbance_recorder_tb_top.sv
/* Self-checking bench: a sample model built from the settings is compared with uploads.
   Assumes the package, design, checker and host model are compiled first. */
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module disturbance_recorder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   base_tick = 1'b0;
  drec_pkg::drec_req_t    bus_req;
  logic [31:0]            rd_data;
  drec_pkg::drec_analog_t analog_in = '0;
  logic [9:0]             prot_signals = '0;
  logic                   binary_input = 1'b0;
  logic [31:0]            time_stamp = '0;
  logic                   display_idle = 1'b1;
  logic                   power_restart = 1'b0;
  logic                   trigger_event;
  logic                   ready_mark;
  logic [31:0]            seed = 32'hb974_9b19;
  int                     miscompares = 0;
  int                     samples_checked = 0;
  int                     events = 0;
  int                     tick_cnt = 0;
  drec_recorder drec_recorder_inst (.clk(clk), .rst(rst), .bus_req(bus_req),
    .rd_data(rd_data), .base_tick(base_tick), .analog_in(analog_in),
    .prot_signals(prot_signals), .binary_input(binary_input), .time_stamp(time_stamp),
    .display_idle(display_idle), .power_restart(power_restart),
    .trigger_event(trigger_event), .ready_mark(ready_mark));
  drec_host_model drec_host_model_inst (.clk(clk), .req(bus_req), .rd_data(rd_data));
  always #2.5 clk = ~clk;
  // Base tick every fourth cycle keeps ticks apart from trigger edges; pulses are counted.
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 1;
    base_tick <= (tick_cnt % 4 == 3);
    if (trigger_event === 1'b1) events <= events + 1;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Digital byte: the first eight selected signals, internal ones before the external one.
  function automatic logic [7:0] dig(logic [10:0] s, logic [10:0] sel);
    int n;
    dig = '0;
    n = 0;
    for (int j = 0; j < 11; j++) begin
      if (sel[j] && n < 8) begin
        dig[n] = s[j];
        n++;
      end
    end
  endfunction : dig
  function automatic logic [31:0] word(drec_pkg::drec_analog_t a, logic r, logic [7:0] d,
                                      logic hi);
    logic [3:0][11:0] c;
    c = r ? a.rms : a.inst;
    return hi ? {d, c[3], c[2]} : {8'h00, c[1], c[0]};
  endfunction : word
  task automatic ticks(int n);
    repeat (n) begin
      @(posedge clk);
      while (base_tick !== 1'b1) @(posedge clk);
    end
  endtask : ticks
  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin : watchdog
    #200_000;
    miscompares++;
    wrap_up();
  end
  // Per pass: rise, fall on the external input, manual, then post length equal to the depth.
  initial begin : main
    logic [31:0] d, ts;
    drec_pkg::drec_analog_t aa, ab, e;
    logic [9:0] pa;
    logic [10:0] sel;
    int div, post, fill, ev;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    drec_host_model_inst.rd(drec_pkg::OFS_STATE_UPLOAD, d);
    `CHK(d, drec_pkg::STAT_IDLE)
    drec_host_model_inst.rd(8'h3C, d);
    `CHK(d, 32'h0000_0000)
    // The event mask must come out of reset enabled.
    drec_host_model_inst.rd(drec_pkg::OFS_EVENT_MASK, d);
    `CHK(d, 32'h0000_0001)
    for (int i = 0; i < 4; i++) begin
      div = (i == 1) ? 2 : (i == 2) ? 16 : 1;
      post = (i == 3) ? 512 : 2 + rnd() % 4;
      d = rnd();
      sel = d[10:0];
      pa = d[30:21] & 10'h3F7;
      aa = {rnd(), rnd(), rnd()};
      ab = {rnd(), rnd(), rnd()};
      ts = rnd();
      analog_in <= aa;
      prot_signals <= pa;
      binary_input <= (i == 1);
      drec_host_model_inst.wr(drec_pkg::OFS_CLEAR, drec_pkg::CMD_ONE);
      drec_host_model_inst.wr(drec_pkg::OFS_SAMPLE_RATE, (i == 3) ? 0 : i);
      drec_host_model_inst.wr(drec_pkg::OFS_DIG_SEL_LOW, {22'h0, sel[9:0]});
      drec_host_model_inst.wr(drec_pkg::OFS_DIG_SEL_HIGH, {31'h0, sel[10]});
      drec_host_model_inst.wr(drec_pkg::OFS_POST_LEN, post);
      drec_host_model_inst.wr(drec_pkg::OFS_TRIG_RISE, (i == 0 || i == 3) ? 8 : 0);
      drec_host_model_inst.wr(drec_pkg::OFS_TRIG_FALL, (i == 1) ? 1024 : 0);
      drec_host_model_inst.wr(drec_pkg::OFS_EVENT_MASK, (i != 1));
      ticks(1);
      drec_host_model_inst.wr(drec_pkg::OFS_CLEAR, drec_pkg::CMD_ONE);
      ticks(3 * div);
      ev = events;
      analog_in <= ab;
      time_stamp <= ts;
      prot_signals <= pa | ((i == 0 || i == 3) ? 10'h008 : 10'h000);
      binary_input <= 1'b0;
      if (i == 2) drec_host_model_inst.wr(drec_pkg::OFS_MANUAL_TRIG, drec_pkg::CMD_ONE);
      drec_host_model_inst.rd(drec_pkg::OFS_STATE_UPLOAD, d);
      `CHK(d, drec_pkg::STAT_IDLE)
      for (int w = 0; w < 1500 && d !== drec_pkg::STAT_READY; w++) begin
        drec_host_model_inst.rd(drec_pkg::OFS_STATE_UPLOAD, d);
      end
      `CHK(d, drec_pkg::STAT_READY)
      `CHK(events - ev, (i != 1) ? 1 : 0)
      fill = (3 + post > 512) ? 512 : 3 + post;
      drec_host_model_inst.rd(drec_pkg::OFS_FILL, d);
      `CHK(d, fill)
      // Rate and channel selection must be refused while a recording is held.
      drec_host_model_inst.wr(drec_pkg::OFS_SAMPLE_RATE, (i == 1) ? 0 : 1);
      drec_host_model_inst.rd(drec_pkg::OFS_SAMPLE_RATE, d);
      `CHK(d, (i == 3) ? 0 : i)
      drec_host_model_inst.wr(drec_pkg::OFS_DIG_SEL_LOW, {22'h0, ~sel[9:0]});
      drec_host_model_inst.rd(drec_pkg::OFS_DIG_SEL_LOW, d);
      `CHK(d, {22'h0, sel[9:0]})
      drec_host_model_inst.wr(drec_pkg::OFS_MANUAL_TRIG, drec_pkg::CMD_ONE);
      display_idle <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(ready_mark, 1'b0)
      display_idle <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(ready_mark, 1'b1)
      // Before the prerequisites are first set an upload read yields zero.
      if (i == 0) begin
        drec_host_model_inst.rd(drec_pkg::OFS_UPLOAD_DATA, d);
        `CHK(d, 32'h0000_0000)
      end
      drec_host_model_inst.prep();
      drec_host_model_inst.rd(drec_pkg::OFS_UPLOAD_DATA, d);
      `CHK(d, ts)
      // Step past the stamp, then rewind: the stamp must come back first.
      drec_host_model_inst.rd(drec_pkg::OFS_UPLOAD_DATA, d);
      drec_host_model_inst.wr(drec_pkg::OFS_STATE_UPLOAD, drec_pkg::CMD_UPLOAD_RST);
      drec_host_model_inst.rd(drec_pkg::OFS_UPLOAD_DATA, d);
      `CHK(d, ts)
      for (int j = 0; j < fill; j++) begin
        e = (j < fill - post) ? aa : ab;
        d = {(j < fill - post) ? i == 1 : 1'b0, (j < fill - post) ? pa : prot_signals};
        for (int h = 0; h < 2; h++) begin
          drec_host_model_inst.rd(drec_pkg::OFS_UPLOAD_DATA, ts);
          `CHK(ts, word(e, i == 2, dig(d[10:0], sel), h))
        end
      end
      drec_host_model_inst.wr(drec_pkg::OFS_CONFIG, {30'h0, i == 2, i == 0});
      drec_host_model_inst.rd(drec_pkg::OFS_CONFIG, d);
      `CHK(d, {30'h0, i == 2, i == 0})
      power_restart <= 1'b1;
      @(posedge clk);
      power_restart <= 1'b0;
      @(posedge clk);
      drec_host_model_inst.rd(drec_pkg::OFS_STATE_UPLOAD, d);
      `CHK(d, (i == 0) ? drec_pkg::STAT_READY : drec_pkg::STAT_IDLE)
    end
    drec_host_model_inst.wr(drec_pkg::OFS_CLEAR, drec_pkg::CMD_ONE);
    drec_host_model_inst.rd(drec_pkg::OFS_FILL, d);
    `CHK(d, 32'h0000_0000)
    wrap_up();
  end
endmodule : disturbance_recorder_tb_top
`default_nettype wire

// >>> verification/drec_host_model.sv
/* Host software model: register reads and writes and the upload preparation.
   Assumes callers enter its tasks right after a rising edge of clk. */
`default_nettype none
module drec_host_model (
  input  wire logic                clk,
  output var  drec_pkg::drec_req_t req,
  input  wire logic [31:0]         rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // Each access leaves one idle cycle so no strobe is assigned twice in a step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    d = rd_data;
  endtask : rd
  // Both prerequisites are set before the upload walker is rewound.
  task automatic prep();
    wr(drec_pkg::OFS_PREREQ_A, 32'h0000_0001);
    wr(drec_pkg::OFS_PREREQ_B, 32'h0000_0001);
    wr(drec_pkg::OFS_STATE_UPLOAD, drec_pkg::CMD_UPLOAD_RST);
  endtask : prep
endmodule : drec_host_model
`default_nettype wire

// >>> verification/drec_recorder_properties.sv
/* Concurrent checks on the recorder's register port, event pulse and ready mark.
   Assumes one clock and a synchronous active-high reset, bound to drec_recorder. */
`default_nettype none
module drec_recorder_properties (
  input wire logic                clk,
  input wire logic                rst,
  input wire drec_pkg::drec_req_t bus_req,
  input wire logic [31:0]         rd_data,
  input wire logic                display_idle,
  input wire logic                trigger_event,
  input wire logic                ready_mark
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mask_q;
  // Shadow of the event mask, so a pulse can be tied to the mask in force at the trigger.
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= drec_pkg::MASK_RESET;
    end else if (bus_req.wr && bus_req.addr == drec_pkg::OFS_EVENT_MASK) begin
      mask_q <= bus_req.wdata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_reset_quiet;
    $past(rst) |-> rd_data == 32'h0000_0000 && !ready_mark && !trigger_event;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");
  property p_rd_idle;
    !$past(bus_req.rd) |-> rd_data == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
  property p_status;
    (bus_req.rd && bus_req.addr == drec_pkg::OFS_STATE_UPLOAD && display_idle)
      |=> rd_data == {31'h0, ready_mark};
  endproperty
  a_status: assert property (p_status) else $error("status disagrees with ready mark");
  property p_pulse;
    trigger_event |=> !trigger_event;
  endproperty
  a_pulse: assert property (p_pulse) else $error("trigger event longer than one cycle");
  property p_masked;
    trigger_event |-> $past(mask_q);
  endproperty
  a_masked: assert property (p_masked) else $error("trigger event while masked");
  property p_no_retrig;
    (bus_req.wr && bus_req.addr == drec_pkg::OFS_MANUAL_TRIG && ready_mark) |=> !trigger_event;
  endproperty
  a_no_retrig: assert property (p_no_retrig) else $error("trigger taken while triggered");
  property p_clear;
    (bus_req.wr && bus_req.addr == drec_pkg::OFS_CLEAR && bus_req.wdata == drec_pkg::CMD_ONE)
      |=> ##1 !ready_mark;
  endproperty
  a_clear: assert property (p_clear) else $error("ready mark survives clear");
  property p_idle_mark;
    ready_mark |-> $past(display_idle);
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("ready mark while display busy");
endmodule : drec_recorder_properties
bind drec_recorder drec_recorder_properties drec_recorder_properties_inst (
  .clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .display_idle(display_idle),
  .trigger_event(trigger_event), .ready_mark(ready_mark));
`default_nettype wire
